// File: acm_pkg.sv
// Constants and types shared by the converter configuration selector
package acm_pkg;

    // ==================== Register bus ====================
    localparam int        ACM_ADDR_W       = 8;
    localparam int        ACM_DATA_W       = 8;
    localparam logic [7:0] ACM_REG_RESET   = 8'h00;
    localparam logic [7:0] ACM_REG_SPEED   = 8'h20;
    localparam logic [7:0] ACM_REG_REFSTBY = 8'h3F;
    localparam logic [7:0] ACM_REG_PDMODE  = 8'h40;
    localparam logic [7:0] ACM_REG_IFACE   = 8'h41;
    localparam logic [7:0] ACM_REG_FORMAT  = 8'h50;
    localparam logic [7:0] ACM_REG_STATUS  = 8'h80;

    // ==================== Field positions ====================
    localparam int ACM_BIT_SWRST    = 7;
    localparam int ACM_BIT_READOUT  = 0;
    localparam int ACM_BIT_LOWSPEED = 2;
    localparam int ACM_BIT_REF      = 6;
    localparam int ACM_BIT_STBY     = 1;
    localparam int ACM_BIT_CMOS     = 7;
    localparam int ACM_BIT_OFFBIN   = 1;
    localparam int ACM_PD_W         = 4;

    // ==================== Reset values ====================
    localparam logic [7:0] ACM_RST_VALUE = 8'h00;

    // ==================== Serial word ====================
    localparam int         ACM_WORD_BITS = 16;
    localparam logic [3:0] ACM_LAST_BIT  = 4'hF;

    // ==================== Strap levels ====================
    typedef enum logic [1:0] {
        ACM_LVL_GND     = 2'b00,
        ACM_LVL_3_8     = 2'b01,
        ACM_LVL_5_8     = 2'b10,
        ACM_LVL_SUPPLY  = 2'b11
    } acm_level_t;

    // Power control pins packed as {pin1, pin2, pin3}
    localparam logic [2:0] ACM_PWR_NORMAL = 3'h0;
    localparam logic [2:0] ACM_PWR_GPD    = 3'h4;
    localparam logic [2:0] ACM_PWR_STBY_B = 3'h5;
    localparam logic [2:0] ACM_PWR_STBY_A = 3'h6;
    localparam logic [2:0] ACM_PWR_MUX    = 3'h7;

    localparam int ACM_SAMPLE_W = 11;

endpackage : acm_pkg

// File: acm_serial_shift.sv
// Serial word receiver: 16 bits per word, sampled on serial clock falling edges
`timescale 1ns/10ps
module acm_serial_shift
    import acm_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  enable,
    input  wire logic                  frame_n,
    input  wire logic                  sclk_fall,
    input  wire logic                  ser_bit,
    output logic                       word_stb,
    output logic [ACM_ADDR_W-1:0]      word_addr,
    output logic [ACM_DATA_W-1:0]      word_data
);

    logic [ACM_WORD_BITS-1:0] shift_q, shift_d;
    logic [3:0]               cnt_q, cnt_d;
    logic                     stb_q, stb_d;
    logic [ACM_WORD_BITS-1:0] word_q, word_d;

    // ==================== Next state ====================
    always_comb begin
        shift_d = shift_q;
        cnt_d   = cnt_q;
        stb_d   = 1'b0;
        word_d  = word_q;
        // Enable low or frame_n high clears the count; bits past a whole word start the next word
        if (!enable || frame_n) begin
            cnt_d = 4'h0;
        end else if (sclk_fall) begin
            shift_d = {shift_q[ACM_WORD_BITS-2:0], ser_bit};
            cnt_d   = cnt_q + 4'h1;
            if (cnt_q == ACM_LAST_BIT) begin
                stb_d  = 1'b1;
                word_d = {shift_q[ACM_WORD_BITS-2:0], ser_bit};
            end
        end
    end

    // ==================== Registers ====================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= '0;
            cnt_q   <= 4'h0;
            stb_q   <= 1'b0;
            word_q  <= '0;
        end else begin
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            stb_q   <= stb_d;
            word_q  <= word_d;
        end
    end

    assign word_stb  = stb_q;
    assign word_addr = word_q[ACM_WORD_BITS-1:ACM_DATA_W];
    assign word_data = word_q[ACM_DATA_W-1:0];

endmodule : acm_serial_shift

// File: acm_config_top.sv
// Configuration mode selector: strap decode, serial registers, output interleave
// Notes on behaviour
// - Reset pin held high selects strap mode.
// - Strap mode needs no reset; data ignored.
// - Clock strap mid levels pick external reference.
// - Enable strap picks format and interface.
// - Power pins decode normal, down, standby, mux.
// - Interleave both channels onto channel A bus.
// - Interleaving only with serial low-speed mode.
// - Pin pulse or soft bit restores defaults.
// - Soft reset bit clears itself afterwards.
`timescale 1ns/10ps
module acm_config_top
    import acm_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    reg_reset_pin,
    input  wire logic                    serial_enable_or_format_strap,
    input  wire logic [1:0]              format_strap_level,
    input  wire logic                    serial_clk_pin,
    input  wire logic [1:0]              ref_strap_level,
    input  wire logic                    serial_data_in,
    input  wire logic                    power_ctl_pin_1,
    input  wire logic                    power_ctl_pin_2,
    input  wire logic                    power_ctl_pin_3,
    input  wire logic [ACM_SAMPLE_W-1:0] chan_a_sample,
    input  wire logic [ACM_SAMPLE_W-1:0] chan_b_sample,
    input  wire logic [ACM_ADDR_W-1:0]   reg_addr,
    input  wire logic [ACM_DATA_W-1:0]   reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [ACM_DATA_W-1:0]        reg_rdata,
    output logic                         parallel_mode,
    output logic                         ref_external,
    output logic                         cmos_interface,
    output logic                         offset_binary,
    output logic                         global_power_down,
    output logic                         chan_a_standby,
    output logic                         chan_b_standby,
    output logic                         interleaved_output_mode,
    output logic                         power_combo_invalid,
    output logic                         interleave_chan_b,
    output logic [ACM_SAMPLE_W-1:0]      chan_a_output_bus,
    output logic [ACM_SAMPLE_W-1:0]      chan_b_output_bus
);

    // ==================== Decode functions ====================
    function automatic logic lvl_is_mid(input logic [1:0] lvl);
        lvl_is_mid = (lvl == ACM_LVL_3_8) || (lvl == ACM_LVL_5_8);
    endfunction : lvl_is_mid

    function automatic logic lvl_is_twos(input logic [1:0] lvl);
        lvl_is_twos = (lvl == ACM_LVL_GND) || (lvl == ACM_LVL_SUPPLY);
    endfunction : lvl_is_twos

    // ==================== Pin synchronisers ====================
    localparam int NSYNC = 7;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync1_q;
    logic [NSYNC-1:0] sync2_q;

    assign pin_raw = {reg_reset_pin, serial_enable_or_format_strap, serial_clk_pin,
                      serial_data_in, power_ctl_pin_1, power_ctl_pin_2, power_ctl_pin_3};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // Level codes are quasi-static straps, but still pass two stages
    logic [1:0] fmt_lvl1_q, fmt_lvl2_q, ref_lvl1_q, ref_lvl2_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fmt_lvl1_q <= ACM_LVL_GND;
            fmt_lvl2_q <= ACM_LVL_GND;
            ref_lvl1_q <= ACM_LVL_GND;
            ref_lvl2_q <= ACM_LVL_GND;
        end else begin
            fmt_lvl1_q <= format_strap_level;
            fmt_lvl2_q <= fmt_lvl1_q;
            ref_lvl1_q <= ref_strap_level;
            ref_lvl2_q <= ref_lvl1_q;
        end
    end

    logic       rstpin_s, frame_n_s, sclk_s, ser_bit_s;
    logic [2:0] pwr_s;
    assign rstpin_s  = sync2_q[6];
    assign frame_n_s = sync2_q[5];
    assign sclk_s    = sync2_q[4];
    assign ser_bit_s = sync2_q[3];
    assign pwr_s     = sync2_q[2:0];

    // ==================== Serial clock edge ====================
    logic sclk_prev_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
        end
    end

    logic sclk_fall;
    assign sclk_fall = sclk_prev_q && !sclk_s;

    // pin high means strap mode, serial pins become mode inputs
    logic strap_mode;
    assign strap_mode = rstpin_s;

    // ==================== Serial receiver ====================
    logic                  ser_stb;
    logic [ACM_ADDR_W-1:0] ser_addr;
    logic [ACM_DATA_W-1:0] ser_data;

    // receiver idle in strap mode, serial data never read
    acm_serial_shift u_shift (
        .clk       (clk),
        .rst_n     (rst_n),
        .enable    (!strap_mode),
        .frame_n   (frame_n_s),
        .sclk_fall (sclk_fall),
        .ser_bit   (ser_bit_s),
        .word_stb  (ser_stb),
        .word_addr (ser_addr),
        .word_data (ser_data)
    );

    // ==================== Register file ====================
    logic                wr_en;
    logic [7:0]          wr_addr;
    logic [7:0]          wr_data;
    logic                swrst_q, swrst_d;
    logic                readout_q, readout_d;
    logic                lowspeed_q, lowspeed_d;
    logic                refsel_q, refsel_d;
    logic                stby_q, stby_d;
    logic [ACM_PD_W-1:0] pdmode_q, pdmode_d;
    logic                cmos_q, cmos_d;
    logic                offbin_q, offbin_d;

    // Serial word wins a same-cycle collision with the parallel port
    always_comb begin
        wr_en   = ser_stb || reg_wr;
        wr_addr = ser_stb ? ser_addr : reg_addr;
        wr_data = ser_stb ? ser_data : reg_wdata;
    end

    always_comb begin
        swrst_d    = 1'b0;
        readout_d  = readout_q;
        lowspeed_d = lowspeed_q;
        refsel_d   = refsel_q;
        stby_d     = stby_q;
        pdmode_d   = pdmode_q;
        cmos_d     = cmos_q;
        offbin_d   = offbin_q;
        // pin high or soft bit returns every field to default
        // writes only land once the pin is back low
        if (strap_mode || swrst_q) begin
            readout_d  = ACM_RST_VALUE[ACM_BIT_READOUT];
            lowspeed_d = ACM_RST_VALUE[ACM_BIT_LOWSPEED];
            refsel_d   = ACM_RST_VALUE[ACM_BIT_REF];
            stby_d     = ACM_RST_VALUE[ACM_BIT_STBY];
            pdmode_d   = ACM_RST_VALUE[ACM_PD_W-1:0];
            cmos_d     = ACM_RST_VALUE[ACM_BIT_CMOS];
            offbin_d   = ACM_RST_VALUE[ACM_BIT_OFFBIN];
        end else if (wr_en) begin
            unique case (wr_addr)
                ACM_REG_RESET: begin
                    // bit held one cycle, then cleared by hardware
                    swrst_d   = wr_data[ACM_BIT_SWRST];
                    readout_d = wr_data[ACM_BIT_READOUT];
                end
                ACM_REG_SPEED:   lowspeed_d = wr_data[ACM_BIT_LOWSPEED];
                ACM_REG_REFSTBY: begin
                    refsel_d = wr_data[ACM_BIT_REF];
                    stby_d   = wr_data[ACM_BIT_STBY];
                end
                ACM_REG_PDMODE:  pdmode_d = wr_data[ACM_PD_W-1:0];
                ACM_REG_IFACE:   cmos_d   = wr_data[ACM_BIT_CMOS];
                ACM_REG_FORMAT:  offbin_d = wr_data[ACM_BIT_OFFBIN];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            swrst_q    <= 1'b0;
            readout_q  <= 1'b0;
            lowspeed_q <= 1'b0;
            refsel_q   <= 1'b0;
            stby_q     <= 1'b0;
            pdmode_q   <= '0;
            cmos_q     <= 1'b0;
            offbin_q   <= 1'b0;
        end else begin
            swrst_q    <= swrst_d;
            readout_q  <= readout_d;
            lowspeed_q <= lowspeed_d;
            refsel_q   <= refsel_d;
            stby_q     <= stby_d;
            pdmode_q   <= pdmode_d;
            cmos_q     <= cmos_d;
            offbin_q   <= offbin_d;
        end
    end

    // ==================== Mode decode ====================
    logic ref_ext_c, cmos_c, offbin_c, gpd_c, stby_a_c, stby_b_c, mux_c, bad_c;

    always_comb begin
        if (strap_mode) begin
            ref_ext_c = lvl_is_mid(ref_lvl2_q);
            // upper two levels CMOS, middle two offset binary
            cmos_c    = fmt_lvl2_q[1];
            offbin_c  = !lvl_is_twos(fmt_lvl2_q);
        end else begin
            ref_ext_c = refsel_q;
            cmos_c    = cmos_q;
            offbin_c  = offbin_q;
        end
        gpd_c    = 1'b0;
        stby_a_c = 1'b0;
        stby_b_c = 1'b0;
        mux_c    = 1'b0;
        bad_c    = 1'b0;
        // power pin table; low-prefixed codes other than zero are flagged
        unique case (pwr_s)
            ACM_PWR_NORMAL: ;
            ACM_PWR_GPD:    gpd_c    = 1'b1;
            ACM_PWR_STBY_B: stby_b_c = 1'b1;
            ACM_PWR_STBY_A: stby_a_c = 1'b1;
            // mux needs serial mode with low speed enabled
            ACM_PWR_MUX:    mux_c    = !strap_mode && lowspeed_q;
            default:        bad_c    = 1'b1;
        endcase
        if (!strap_mode) begin
            gpd_c    = gpd_c || stby_q || (pdmode_q != '0);
        end
    end

    // ==================== Output data path ====================
    logic                    phase_q, phase_d;
    logic                    bslot_q, bslot_d;
    logic [ACM_SAMPLE_W-1:0] outa_q, outa_d, outb_q, outb_d;
    logic [ACM_DATA_W-1:0]   rdata_q, rdata_d;
    logic [7:0]              status_c;

    assign status_c = {strap_mode, ref_ext_c, cmos_c, offbin_c,
                       gpd_c, stby_a_c, stby_b_c, mux_c};

    always_comb begin
        phase_d = 1'b0;
        bslot_d = 1'b0;
        outa_d  = chan_a_sample;
        outb_d  = chan_b_sample;
        // alternate A then B on channel A bus
        if (mux_c) begin
            phase_d = !phase_q;
            // Marker registered with the bus, so it never leads the data
            bslot_d = phase_q;
            outa_d  = phase_q ? chan_b_sample : chan_a_sample;
        end
        rdata_d = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                ACM_REG_RESET:   rdata_d[ACM_BIT_READOUT]  = readout_q;
                ACM_REG_SPEED:   rdata_d[ACM_BIT_LOWSPEED] = lowspeed_q;
                ACM_REG_REFSTBY: begin
                    rdata_d[ACM_BIT_REF]  = refsel_q;
                    rdata_d[ACM_BIT_STBY] = stby_q;
                end
                ACM_REG_PDMODE:  rdata_d[ACM_PD_W-1:0]     = pdmode_q;
                ACM_REG_IFACE:   rdata_d[ACM_BIT_CMOS]     = cmos_q;
                ACM_REG_FORMAT:  rdata_d[ACM_BIT_OFFBIN]   = offbin_q;
                ACM_REG_STATUS:  rdata_d                   = status_c;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= 1'b0;
            bslot_q <= 1'b0;
            outa_q  <= '0;
            outb_q  <= '0;
            rdata_q <= '0;
        end else begin
            phase_q <= phase_d;
            bslot_q <= bslot_d;
            outa_q  <= outa_d;
            outb_q  <= outb_d;
            rdata_q <= rdata_d;
        end
    end

    // ==================== Outputs ====================
    assign reg_rdata               = rdata_q;
    assign parallel_mode           = strap_mode;
    assign ref_external            = ref_ext_c;
    assign cmos_interface          = cmos_c;
    assign offset_binary           = offbin_c;
    assign global_power_down       = gpd_c;
    assign chan_a_standby          = stby_a_c;
    assign chan_b_standby          = stby_b_c;
    assign interleaved_output_mode = mux_c;
    assign power_combo_invalid     = bad_c;
    assign interleave_chan_b       = bslot_q;
    assign chan_a_output_bus       = outa_q;
    assign chan_b_output_bus       = outb_q;

endmodule : acm_config_top

// File: acm_config_checker.sv
// Port-level assertions for the configuration mode selector
`timescale 1ns/10ps
module acm_config_checker
    import acm_pkg::*;
(
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic                    reg_reset_pin,
    input wire logic                    serial_enable_or_format_strap,
    input wire logic [1:0]              format_strap_level,
    input wire logic                    serial_clk_pin,
    input wire logic [1:0]              ref_strap_level,
    input wire logic                    serial_data_in,
    input wire logic                    power_ctl_pin_1,
    input wire logic                    power_ctl_pin_2,
    input wire logic                    power_ctl_pin_3,
    input wire logic [ACM_SAMPLE_W-1:0] chan_a_sample,
    input wire logic [ACM_SAMPLE_W-1:0] chan_b_sample,
    input wire logic [ACM_ADDR_W-1:0]   reg_addr,
    input wire logic [ACM_DATA_W-1:0]   reg_wdata,
    input wire logic                    reg_wr,
    input wire logic                    reg_rd,
    input wire logic [ACM_DATA_W-1:0]   reg_rdata,
    input wire logic                    parallel_mode,
    input wire logic                    ref_external,
    input wire logic                    cmos_interface,
    input wire logic                    offset_binary,
    input wire logic                    global_power_down,
    input wire logic                    chan_a_standby,
    input wire logic                    chan_b_standby,
    input wire logic                    interleaved_output_mode,
    input wire logic                    power_combo_invalid,
    input wire logic                    interleave_chan_b,
    input wire logic [ACM_SAMPLE_W-1:0] chan_a_output_bus,
    input wire logic [ACM_SAMPLE_W-1:0] chan_b_output_bus
);
    // ==================== Properties ====================
    // Five stable cycles cover the two-flop pin synchroniser
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [2:0] pwr;
    assign pwr = {power_ctl_pin_1, power_ctl_pin_2, power_ctl_pin_3};

    a_strap_mode_entry: assert property (reg_reset_pin [*5] |-> parallel_mode)
        else $error("strap mode not entered");
    a_serial_mode_entry: assert property (!reg_reset_pin [*5] |-> !parallel_mode)
        else $error("serial mode not entered");
    a_ref_mid_level: assert property (
        (reg_reset_pin && ref_strap_level inside {2'h1, 2'h2}) [*5] |-> ref_external)
        else $error("mid level did not pick external reference");
    a_ref_rail_level: assert property (
        (reg_reset_pin && ref_strap_level inside {2'h0, 2'h3}) [*5] |-> !ref_external)
        else $error("rail level picked external reference");
    a_format_decode: assert property (
        (reg_reset_pin && $stable(format_strap_level)) [*5]
        |-> cmos_interface == format_strap_level[1]
        && offset_binary == (format_strap_level inside {2'h1, 2'h2}))
        else $error("format strap decode wrong");
    a_power_decode: assert property ((reg_reset_pin && $stable(pwr)) [*5]
        |-> global_power_down == (pwr == ACM_PWR_GPD) && chan_b_standby == (pwr == ACM_PWR_STBY_B)
        && chan_a_standby == (pwr == ACM_PWR_STBY_A)) else $error("power pin decode wrong");
    a_power_invalid: assert property ($stable(pwr) [*5]
        |-> power_combo_invalid == (pwr inside {3'h1, 3'h2, 3'h3}))
        else $error("invalid power code flag wrong");
    a_no_strap_mux: assert property (parallel_mode |-> !interleaved_output_mode)
        else $error("interleave active in strap mode");
    a_mux_b_sample: assert property (
        interleave_chan_b |-> chan_a_output_bus == $past(chan_b_sample))
        else $error("channel B sample missing on bus A");
    a_mux_a_sample: assert property (interleaved_output_mode && !interleave_chan_b
        |-> chan_a_output_bus == $past(chan_a_sample)) else $error("channel A sample wrong");
    a_mux_alternates: assert property (interleaved_output_mode && interleave_chan_b
        |=> !interleave_chan_b) else $error("two B slots in a row");
    // Bit lands one edge after the write, defaults one edge later
    a_soft_reset_clears: assert property (
        reg_wr && reg_addr == ACM_REG_RESET && reg_wdata[ACM_BIT_SWRST] && !parallel_mode
        && !reg_reset_pin |=> ##1 !cmos_interface && !offset_binary && !ref_external)
        else $error("soft reset left fields set");

    cover property (interleave_chan_b);
    cover property (parallel_mode && ref_external && cmos_interface);
    cover property (power_combo_invalid);
endmodule : acm_config_checker

// File: acm_serial_host.sv
// Host controller model driving the serial enable, clock and data pins
`timescale 1ns/10ps
module acm_serial_host (
    input  wire logic clk,
    output logic      en_n,
    output logic      sclk,
    output logic      data_out
);
    // ==================== Idle levels ====================
    // Enable has a pull-up, clock and data pull-downs; clock is still between words
    initial begin
        en_n  = 1'b1;
        sclk     = 1'b0;
        data_out = 1'b0;
    end

    // ==================== Word transfer ====================
    // address then data
    task automatic send_word(input logic [7:0] addr, input logic [7:0] data);
        logic [15:0] w;
        w = {addr, data};
        @(posedge clk);
        en_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            data_out <= w[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        en_n     <= 1'b1;
        data_out <= 1'b0;
    endtask : send_word
endmodule : acm_serial_host

// File: acm_config_top_tb.sv
// Self-checking testbench for the configuration mode selector
`timescale 1ns/10ps
module acm_config_top_tb;
    import acm_pkg::*;
    logic clk, rst_n, reg_reset_pin, serial_enable_or_format_strap, serial_clk_pin;
    logic serial_data_in, power_ctl_pin_1, power_ctl_pin_2, power_ctl_pin_3, reg_wr, reg_rd;
    logic [1:0] format_strap_level, ref_strap_level;
    logic [ACM_SAMPLE_W-1:0] chan_a_sample, chan_b_sample, chan_a_output_bus, chan_b_output_bus;
    logic [ACM_SAMPLE_W-1:0] ea, eb;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic parallel_mode, ref_external, cmos_interface, offset_binary, global_power_down;
    logic chan_a_standby, chan_b_standby, interleaved_output_mode, power_combo_invalid;
    logic interleave_chan_b, pb;
    logic [8:0] flags;
    int miscompares, samples_checked, cycles;
    integer seed = 32'hab00;

    assign flags = {parallel_mode, ref_external, cmos_interface, offset_binary, global_power_down,
                    chan_a_standby, chan_b_standby, interleaved_output_mode, power_combo_invalid};

    acm_config_top i_acm_config_top (.*);
    acm_serial_host i_acm_serial_host (.clk(clk), .en_n(serial_enable_or_format_strap),
        .sclk(serial_clk_pin), .data_out(serial_data_in));

    // ==================== Clock and stimulus ====================
    always #4 clk = ~clk;
    always @(posedge clk) begin
        chan_a_sample <= ACM_SAMPLE_W'($random(seed));
        chan_b_sample <= ACM_SAMPLE_W'($random(seed));
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ==================== Tasks ====================
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        reg_addr  <= addr;
        reg_wdata <= data;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= addr;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", 16'(exp), 16'(reg_rdata));
    endtask : reg_read

    task automatic hw_pulse;
        @(posedge clk);
        reg_reset_pin <= 1'b1;
        repeat (4) @(posedge clk);
        reg_reset_pin <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : hw_pulse

    function automatic logic [8:0] exp_par(input logic [1:0] r, input logic [1:0] f,
                                           input logic [2:0] p);
        return {1'b1, r == 2'h1 || r == 2'h2, f[1], f == 2'h1 || f == 2'h2, p == ACM_PWR_GPD,
                p == ACM_PWR_STBY_A, p == ACM_PWR_STBY_B, 1'b0, p inside {3'h1, 3'h2, 3'h3}};
    endfunction : exp_par

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // ==================== Main sequence ====================
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        reg_reset_pin = 1'b0;
        {format_strap_level, ref_strap_level} = 4'h0;
        {power_ctl_pin_1, power_ctl_pin_2, power_ctl_pin_3} = 3'h0;
        {chan_a_sample, chan_b_sample} = '0;
        {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {miscompares, samples_checked, cycles} = '0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        hw_pulse();
        reg_read(ACM_REG_STATUS, 8'h00);
        i_acm_serial_host.send_word(ACM_REG_IFACE, 8'h80);
        i_acm_serial_host.send_word(ACM_REG_FORMAT, 8'h02);
        reg_write(ACM_REG_REFSTBY, 8'h40);
        reg_write(8'h33, 8'hFF);
        reg_write(ACM_REG_PDMODE, 8'h03);
        repeat (8) @(posedge clk);
        reg_read(ACM_REG_STATUS, 8'h78);
        reg_read(ACM_REG_PDMODE, 8'h03);
        reg_read(ACM_REG_IFACE, 8'h80);
        reg_read(8'h33, 8'h00);
        $display("test serial configuration done");
        reg_write(ACM_REG_RESET, 8'h80);
        reg_read(ACM_REG_RESET, 8'h00);
        reg_read(ACM_REG_STATUS, 8'h00);
        reg_write(ACM_REG_IFACE, 8'h80);
        hw_pulse();
        reg_read(ACM_REG_STATUS, 8'h00);
        $display("test register reset done");
        reg_reset_pin <= 1'b1;
        i_acm_serial_host.send_word(ACM_REG_IFACE, 8'h80);
        reg_write(ACM_REG_IFACE, 8'h80);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            ref_strap_level    <= 2'(i);
            format_strap_level <= 2'(i >> 2);
            {power_ctl_pin_1, power_ctl_pin_2, power_ctl_pin_3} <= 3'(i);
            repeat (6) @(posedge clk);
            #1;
            check("strap flags", 16'(exp_par(2'(i), 2'(i >> 2), 3'(i))), 16'(flags));
        end
        $display("test strap decode done");
        reg_reset_pin <= 1'b0;
        {power_ctl_pin_1, power_ctl_pin_2, power_ctl_pin_3} <= 3'h0;
        repeat (6) @(posedge clk);
        reg_read(ACM_REG_STATUS, 8'h00);
        {power_ctl_pin_1, power_ctl_pin_2, power_ctl_pin_3} <= 3'h7;
        reg_write(ACM_REG_SPEED, 8'h04);
        repeat (6) @(posedge clk);
        #1;
        check("interleaved_output_mode", 16'h1, 16'(interleaved_output_mode));
        pb = interleave_chan_b;
        repeat (24) begin
            @(negedge clk);
            ea = chan_a_sample;
            eb = chan_b_sample;
            @(posedge clk);
            #1;
            check("chan_a_output_bus", 16'(pb ? ea : eb), 16'(chan_a_output_bus));
            check("chan_b_output_bus", 16'(eb), 16'(chan_b_output_bus));
            pb = interleave_chan_b;
        end
        $display("test interleave done");
        tally_and_finish();
    end
endmodule : acm_config_top_tb

bind acm_config_top acm_config_checker i_acm_config_checker (.*);
